// ---- rtl/addr_modes_map.svh ----
`ifndef ADDR_MODES_MAP_SVH
`define ADDR_MODES_MAP_SVH

// Register selector codes carried by the opcode
`define SEL_WORKING 2'h0
`define SEL_OFFSET 2'h1
`define SEL_COND 2'h2
`define SEL_STACK 2'h3

// Instruction lengths in bytes
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

// Reset values of the core registers
`define RST_WORKING 8'h00
`define RST_OFFSET 8'h00
`define RST_COND 8'h00
`define RST_STACK 8'h00

// Carry position in the condition bits
`define COND_CARRY_BIT 2

// Pointer post-increment step
`define PTR_STEP 8'h01

// Memory space select codes
`define SPACE_RAM 1'b0
`define SPACE_REG 1'b1

`endif

// ---- rtl/addr_modes_pkg.sv ----
package addr_modes_pkg;

	typedef enum logic [3:0] {
		MODE_SRC_IMM,
		MODE_SRC_DIR,
		MODE_SRC_IDX,
		MODE_DST_DIR,
		MODE_DST_IDX,
		MODE_DST_DIR_IMM,
		MODE_DST_IDX_IMM,
		MODE_DST_DIR_DIR,
		MODE_SRC_IND_INC,
		MODE_DST_IND_INC
	} addr_mode_e;

	typedef enum logic [2:0] {
		OP_COPY,
		OP_ADD,
		OP_ADC,
		OP_SUB,
		OP_SBB,
		OP_AND,
		OP_OR,
		OP_XOR
	} alu_op_e;

endpackage : addr_modes_pkg

// ---- rtl/operand_alu.sv ----
`timescale 1ns/1ps

// Combining unit: y = a op b; copy passes b through
module operand_alu #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] a,
	input wire logic [WIDTH-1:0] b,
	input wire logic carry_in,
	input wire addr_modes_pkg::alu_op_e op,
	output logic [WIDTH-1:0] y
);

	logic [WIDTH-1:0] cin_ext;

	always_comb
	begin
		cin_ext = '0;
		cin_ext[0] = carry_in;
		case (op)
			addr_modes_pkg::OP_COPY: y = b;
			addr_modes_pkg::OP_ADD: y = a + b;
			addr_modes_pkg::OP_ADC: y = a + b + cin_ext;
			addr_modes_pkg::OP_SUB: y = a - b;
			addr_modes_pkg::OP_SBB: y = a - b - cin_ext;
			addr_modes_pkg::OP_AND: y = a & b;
			addr_modes_pkg::OP_OR: y = a | b;
			addr_modes_pkg::OP_XOR: y = a ^ b;
			default: y = b;
		endcase
	end

endmodule : operand_alu

// ---- rtl/operand_addressing_modes.sv ----
`timescale 1ns/1ps
`include "addr_modes_map.svh"

module operand_addressing_modes #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] mode,
	input wire logic [2:0] alu_op,
	input wire logic [1:0] reg_sel,
	input wire logic reg_space,
	input wire logic [WIDTH-1:0] opnd1,
	input wire logic [WIDTH-1:0] opnd2,
	input wire logic mem_ack,
	input wire logic [WIDTH-1:0] mem_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic mem_space,
	output logic [WIDTH-1:0] mem_addr,
	output logic [WIDTH-1:0] mem_wdata,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [1:0] inst_len,
	output logic [WIDTH-1:0] working,
	output logic [WIDTH-1:0] offset,
	output logic [WIDTH-1:0] cond_bits,
	output logic [WIDTH-1:0] stack_top_ptr
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PTR_RD,
		ST_OPND_RD,
		ST_RES_WR,
		ST_PTR_WR,
		ST_FINISH
	} state_e;

	state_e state_q;
	addr_modes_pkg::addr_mode_e mode_q, mode_in;
	addr_modes_pkg::alu_op_e op_q, alu_fn;
	logic [1:0] sel_q, len_q;
	logic [WIDTH-1:0] b1_q, ea_q, src_q, data_q, ptr_q, ea_d;
	logic [WIDTH-1:0] working_q, offset_q, cond_q, stack_q;
	logic [WIDTH-1:0] mem_addr_q, mem_wdata_q;
	logic [WIDTH-1:0] reg_val, reg_in, alu_a, alu_b, alu_y;
	logic space_q, mem_req_q, mem_we_q, mem_space_q;
	logic done_q, illegal_q, busy_q;
	logic bad_combo, is_copy, is_indexed, is_src_mode, take, acked;

	assign mode_in = addr_modes_pkg::addr_mode_e'(mode);
	assign is_copy = alu_op == 3'(addr_modes_pkg::OP_COPY);
	assign take = start && (state_q == ST_IDLE);
	assign acked = mem_req_q && mem_ack;
	assign is_src_mode = (mode_q == addr_modes_pkg::MODE_SRC_IMM)
		|| (mode_q == addr_modes_pkg::MODE_SRC_DIR)
		|| (mode_q == addr_modes_pkg::MODE_SRC_IDX);

	// Indexed address wraps in WIDTH bits
	assign is_indexed = (mode_in == addr_modes_pkg::MODE_SRC_IDX)
		|| (mode_in == addr_modes_pkg::MODE_DST_IDX)
		|| (mode_in == addr_modes_pkg::MODE_DST_IDX_IMM);
	assign ea_d = is_indexed ? opnd1 + offset_q : opnd1;

	assign reg_in = (reg_sel == `SEL_OFFSET) ? offset_q
		: (reg_sel == `SEL_COND) ? cond_q
		: (reg_sel == `SEL_STACK) ? stack_q : working_q;

	assign reg_val = (sel_q == `SEL_OFFSET) ? offset_q
		: (sel_q == `SEL_COND) ? cond_q
		: (sel_q == `SEL_STACK) ? stack_q : working_q;

	// Mode and opcode pairings that are not allowed
	always_comb
	begin
		bad_combo = 1'b0;
		case (mode_in)
			addr_modes_pkg::MODE_SRC_IMM: bad_combo = 1'b0;
			addr_modes_pkg::MODE_SRC_DIR,
			addr_modes_pkg::MODE_SRC_IDX,
			addr_modes_pkg::MODE_DST_DIR:
				bad_combo = reg_sel[1];
			addr_modes_pkg::MODE_DST_IDX:
				bad_combo = reg_sel != `SEL_WORKING;
			addr_modes_pkg::MODE_DST_DIR_IMM,
			addr_modes_pkg::MODE_DST_IDX_IMM: bad_combo = 1'b0;
			addr_modes_pkg::MODE_DST_DIR_DIR,
			addr_modes_pkg::MODE_SRC_IND_INC,
			addr_modes_pkg::MODE_DST_IND_INC:
				bad_combo = !is_copy;
			default: bad_combo = 1'b1;
		endcase
	end

	// Memory result combines old value; register result the register
	assign alu_a = (state_q == ST_OPND_RD) ? mem_rdata : reg_val;
	assign alu_b = (state_q == ST_OPND_RD) ? src_q : data_q;
	assign alu_fn = op_q;

	operand_alu #(
		.WIDTH(WIDTH)
	) u_alu (
		.a(alu_a),
		.b(alu_b),
		.carry_in(cond_q[`COND_CARRY_BIT]),
		.op(alu_fn),
		.y(alu_y)
	);

	// Operand latches and instruction length
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			len_q <= `LEN_TWO;
		else if (take)
		begin
			mode_q <= mode_in;
			op_q <= addr_modes_pkg::alu_op_e'(alu_op);
			sel_q <= reg_sel;
			space_q <= reg_space;
			b1_q <= opnd1;
			ea_q <= ea_d;
			if (mode_in == addr_modes_pkg::MODE_DST_DIR_IMM
				|| mode_in == addr_modes_pkg::MODE_DST_IDX_IMM)
				src_q <= opnd2;
			else
				src_q <= reg_in;
			if (mode_in == addr_modes_pkg::MODE_DST_DIR_IMM
				|| mode_in == addr_modes_pkg::MODE_DST_IDX_IMM
				|| mode_in == addr_modes_pkg::MODE_DST_DIR_DIR)
				len_q <= `LEN_THREE;
			else
				len_q <= `LEN_TWO;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			data_q <= '0;
			ptr_q <= '0;
		end
		else if (acked && !mem_we_q)
		begin
			if (state_q == ST_PTR_RD)
				ptr_q <= mem_rdata;
			data_q <= mem_rdata;
		end
		else if (take && mode_in == addr_modes_pkg::MODE_SRC_IMM)
			data_q <= opnd1;
	end

	// Sequencer and memory port
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_space_q <= `SPACE_RAM;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (take && bad_combo)
						illegal_q <= 1'b1;
					else if (take)
					begin
						mem_space_q <= reg_space;
						mem_addr_q <= ea_d;
						mem_we_q <= 1'b0;
						mem_wdata_q <= reg_in;
						busy_q <= 1'b1;
						mem_req_q <= mode_in != addr_modes_pkg::MODE_SRC_IMM;
						if (mode_in == addr_modes_pkg::MODE_SRC_IMM)
							state_q <= ST_FINISH;
						else if (mode_in == addr_modes_pkg::MODE_SRC_IND_INC
							|| mode_in == addr_modes_pkg::MODE_DST_IND_INC)
							state_q <= ST_PTR_RD;
						else if (mode_in == addr_modes_pkg::MODE_DST_DIR_DIR)
						begin
							mem_space_q <= `SPACE_RAM;
							mem_addr_q <= opnd2;
							state_q <= ST_OPND_RD;
						end
						else if (is_copy && mode_in != addr_modes_pkg::MODE_SRC_DIR
							&& mode_in != addr_modes_pkg::MODE_SRC_IDX)
						begin
							mem_we_q <= 1'b1;
							if (mode_in == addr_modes_pkg::MODE_DST_DIR_IMM
								|| mode_in == addr_modes_pkg::MODE_DST_IDX_IMM)
								mem_wdata_q <= opnd2;
							state_q <= ST_RES_WR;
						end
						else
							state_q <= ST_OPND_RD;
					end
				end
				ST_PTR_RD:
				begin
					if (acked)
					begin
						mem_addr_q <= mem_rdata;
						if (mode_q == addr_modes_pkg::MODE_SRC_IND_INC)
							state_q <= ST_OPND_RD;
						else
						begin
							mem_we_q <= 1'b1;
							mem_wdata_q <= working_q;
							state_q <= ST_RES_WR;
						end
					end
				end
				ST_OPND_RD:
				begin
					if (acked && mode_q == addr_modes_pkg::MODE_SRC_IND_INC)
					begin
						mem_we_q <= 1'b1;
						mem_space_q <= space_q;
						mem_addr_q <= b1_q;
						mem_wdata_q <= ptr_q + `PTR_STEP;
						state_q <= ST_PTR_WR;
					end
					else if (acked && is_src_mode)
					begin
						mem_req_q <= 1'b0;
						state_q <= ST_FINISH;
					end
					else if (acked)
					begin
						mem_we_q <= 1'b1;
						mem_addr_q <= ea_q;
						if (mode_q == addr_modes_pkg::MODE_DST_DIR_DIR)
							mem_wdata_q <= mem_rdata;
						else
							mem_wdata_q <= alu_y;
						state_q <= ST_RES_WR;
					end
				end
				ST_RES_WR, ST_PTR_WR:
				begin
					if (acked && state_q == ST_RES_WR
						&& mode_q == addr_modes_pkg::MODE_DST_IND_INC)
					begin
						mem_space_q <= space_q;
						mem_addr_q <= b1_q;
						mem_wdata_q <= ptr_q + `PTR_STEP;
						state_q <= ST_PTR_WR;
					end
					else if (acked)
					begin
						mem_req_q <= 1'b0;
						mem_we_q <= 1'b0;
						state_q <= ST_FINISH;
					end
				end
				ST_FINISH:
				begin
					done_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default:
				begin
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Indirect source loads the read byte into working
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			working_q <= `RST_WORKING;
			offset_q <= `RST_OFFSET;
			cond_q <= `RST_COND;
			stack_q <= `RST_STACK;
		end
		else if (state_q == ST_FINISH
			&& (is_src_mode || mode_q == addr_modes_pkg::MODE_SRC_IND_INC))
		begin
			if (mode_q == addr_modes_pkg::MODE_SRC_IND_INC
				|| sel_q == `SEL_WORKING)
				working_q <= alu_y;
			else if (sel_q == `SEL_OFFSET)
				offset_q <= alu_y;
			else if (sel_q == `SEL_COND)
				cond_q <= alu_y;
			else
				stack_q <= alu_y;
		end
	end
	// Destination modes never load a core register

	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_space = mem_space_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign busy = busy_q;
	assign done = done_q;
	assign illegal = illegal_q;
	assign inst_len = len_q;
	assign working = working_q;
	assign offset = offset_q;
	assign cond_bits = cond_q;
	assign stack_top_ptr = stack_q;

endmodule : operand_addressing_modes

// ---- bench/addr_modes_sva.sv ----
`timescale 1ns/1ps
module addr_modes_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] mode,
	input wire logic [2:0] alu_op,
	input wire logic [1:0] reg_sel,
	input wire logic [7:0] opnd1,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [7:0] mem_addr,
	input wire logic busy,
	input wire logic done,
	input wire logic illegal,
	input wire logic [1:0] inst_len,
	input wire logic [7:0] working,
	input wire logic [7:0] offset
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic tk;
	assign tk = start && !busy;
	chk_idx_dst_refused: assert property (tk && mode == 4'h4 && reg_sel != 2'h0
		|=> illegal && !mem_req) else $error("indexed store source refused late");
	chk_copy_only: assert property (tk && mode == 4'h7 && alu_op != 3'h0
		|=> illegal) else $error("direct pair accepted non-copy");
	chk_len_three: assert property (tk && (mode == 4'h5 || mode == 4'h6)
		|=> inst_len == 2'h3) else $error("immediate store length wrong");
	chk_imm_load: assert property (tk && mode == 4'h0 && alu_op == 3'h0
		&& reg_sel == 2'h0 |-> ##2 done && working == $past(opnd1, 2))
		else $error("immediate load wrong");
	chk_idx_addr: assert property (tk && mode == 4'h2 && !reg_sel[1]
		|=> mem_req && !mem_we && mem_addr == 8'($past(opnd1) + $past(offset)))
		else $error("indexed source address wrong");
	chk_dst_write: assert property (tk && mode == 4'h3 && alu_op == 3'h0
		&& !reg_sel[1] |=> mem_req && mem_we && mem_addr == $past(opnd1))
		else $error("direct store access wrong");
	chk_ind_ptr: assert property (tk && mode == 4'h8 && alu_op == 3'h0
		|=> mem_req && !mem_we && mem_addr == $past(opnd1))
		else $error("pointer fetch wrong");
	chk_acc_kept: assert property (tk && (mode == 4'h3 || mode == 4'h9)
		|=> $stable(working) [*3]) else $error("working changed by store");
endmodule : addr_modes_sva

bind operand_addressing_modes addr_modes_sva chk (.ref_clk, .rst_n, .start,
	.mode, .alu_op, .reg_sel, .opnd1, .mem_req, .mem_we, .mem_addr, .busy,
	.done, .illegal, .inst_len, .working, .offset);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic [3:0] mode = 4'h0;
	logic [2:0] alu_op = 3'h0;
	logic [1:0] reg_sel = 2'h0;
	logic reg_space = 1'b0;
	logic [7:0] opnd1 = 8'h00;
	logic [7:0] opnd2 = 8'h00;
	logic mem_ack = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic mem_req, mem_we, mem_space, busy, done, illegal, ill;
	logic [7:0] mem_addr, mem_wdata, working, offset, cond_bits, stack_top_ptr;
	logic [1:0] inst_len;
	logic [7:0] mem [512];
	int fails = 0;
	int check_count = 0;
	operand_addressing_modes #(.WIDTH(8)) dut (.ref_clk, .rst_n, .start,
		.mode, .alu_op, .reg_sel, .reg_space, .opnd1, .opnd2, .mem_ack,
		.mem_rdata, .mem_req, .mem_we, .mem_space, .mem_addr, .mem_wdata,
		.busy, .done, .illegal, .inst_len, .working, .offset, .cond_bits,
		.stack_top_ptr);
	initial forever #2 ref_clk = ~ref_clk;
	// Memory answers every access one cycle late; idle data toggles
	always @(posedge ref_clk)
	begin
		mem_ack <= mem_req && !mem_ack;
		mem_rdata <= (mem_req && !mem_ack) ? mem[{mem_space, mem_addr}] : ~mem_rdata;
		if (mem_req && mem_ack && mem_we)
			mem[{mem_space, mem_addr}] <= mem_wdata;
	end
	task automatic end_sim;
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic run(input logic [3:0] m, input logic [2:0] op,
		input logic [1:0] sel, input logic sp, input logic [7:0] b1, b2);
		int n;
		@(posedge ref_clk);
		mode <= m;
		alu_op <= op;
		reg_sel <= sel;
		reg_space <= sp;
		opnd1 <= b1;
		opnd2 <= b2;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		n = 0;
		#1;
		while (done !== 1'b1 && illegal !== 1'b1 && n < 40)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 40)
		begin
			fails++;
			end_sim();
		end
		ill = illegal;
	endtask : run
	task automatic sc_imm;
		run(4'h0, 3'h0, 2'h0, 1'b0, 8'h35, 8'h00);
		check8(working, 8'h35);
		check8({6'h0, inst_len}, 8'h02);
		run(4'h0, 3'h1, 2'h0, 1'b0, 8'h0b, 8'h00);
		check8(working, 8'h40);
		run(4'h0, 3'h0, 2'h2, 1'b0, 8'h01, 8'h00);
		check8(cond_bits, 8'h01);
		run(4'h0, 3'h0, 2'h3, 1'b0, 8'h7f, 8'h00);
		check8(stack_top_ptr, 8'h7f);
		run(4'h0, 3'h3, 2'h3, 1'b0, 8'h0f, 8'h00);
		check8(stack_top_ptr, 8'h70);
		run(4'h0, 3'h7, 2'h2, 1'b0, 8'h05, 8'h00);
		check8(cond_bits, 8'h04);
	endtask : sc_imm
	task automatic sc_src;
		mem[9'h020] = 8'h11;
		mem[9'h108] = 8'h22;
		mem[9'h012] = 8'h5a;
		run(4'h1, 3'h1, 2'h0, 1'b0, 8'h20, 8'h00);
		check8(working, 8'h51);
		run(4'h1, 3'h0, 2'h1, 1'b1, 8'h08, 8'h00);
		check8(offset, 8'h22);
		run(4'h1, 3'h0, 2'h2, 1'b0, 8'h08, 8'h00);
		check8({7'h0, ill}, 8'h01);
		run(4'h2, 3'h0, 2'h0, 1'b0, 8'hf0, 8'h00);
		check8(working, 8'h5a);
	endtask : sc_src
	task automatic sc_dst;
		mem[9'h030] = 8'h01;
		run(4'h3, 3'h1, 2'h0, 1'b0, 8'h30, 8'h00);
		check8(mem[9'h030], 8'h5b);
		check8(working, 8'h5a);
		run(4'h3, 3'h0, 2'h0, 1'b1, 8'h08, 8'h00);
		check8(mem[9'h108], 8'h5a);
		run(4'h4, 3'h0, 2'h0, 1'b1, 8'h05, 8'h00);
		check8(mem[9'h127], 8'h5a);
		run(4'h4, 3'h0, 2'h1, 1'b0, 8'h05, 8'h00);
		check8({7'h0, ill}, 8'h01);
	endtask : sc_dst
	task automatic sc_three;
		mem[9'h040] = 8'hab;
		run(4'h5, 3'h1, 2'h0, 1'b0, 8'h30, 8'h05);
		check8(mem[9'h030], 8'h60);
		check8({6'h0, inst_len}, 8'h03);
		run(4'h6, 3'h0, 2'h0, 1'b0, 8'he0, 8'h77);
		check8(mem[9'h002], 8'h77);
		run(4'h7, 3'h0, 2'h0, 1'b1, 8'h41, 8'h40);
		check8(mem[9'h041], 8'hab);
		check8({6'h0, inst_len}, 8'h03);
		run(4'h7, 3'h1, 2'h0, 1'b0, 8'h41, 8'h40);
		check8({7'h0, ill}, 8'h01);
	endtask : sc_three
	task automatic sc_ind;
		mem[9'h050] = 8'h60;
		mem[9'h060] = 8'hc3;
		mem[9'h051] = 8'h70;
		run(4'h8, 3'h0, 2'h0, 1'b0, 8'h50, 8'h00);
		check8(working, 8'hc3);
		check8(mem[9'h050], 8'h61);
		run(4'h9, 3'h0, 2'h0, 1'b0, 8'h51, 8'h00);
		check8(mem[9'h070], 8'hc3);
		check8(mem[9'h051], 8'h71);
	endtask : sc_ind
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		sc_imm();
		sc_src();
		sc_dst();
		sc_three();
		sc_ind();
		end_sim();
	end
endmodule : testbench
